// *** hdl/bsr_blit_ctrl.sv ***
// Blit start/status control, raster-operation select and host access routing.
// Summary of operation
// [R01] Pause halts system source; writes reach frame buffer.
// [R02] Host reads always serviced with valid data.
// [R03] Unpaused writes feed engine when it needs data.
// [R04] Host keeps start bit zero when toggling pause.
// [R05] Buffered bit shows parameter set awaiting start.
// [R06] Reset bit aborts and clears the whole engine.
// [R07] Start launches blit at next memory slot.
// [R08] Start bit self-clears when blit finishes.
// [R09] Busy bit reads one while blit runs; the code reads zero while a running blit is paused.
// [R10] Eight-bit field selects one of 16 functions.
// [R11] Software avoids source-free functions with colour expansion.
// [R12] Same code serves source and pattern operands.
// [R13] Codes 00, 0E, 0B: zero, one, inverted destination.
// [R14] Codes 0D, 06, D0: source, destination, inverted source.
// [R15] Codes 05, 09, 50: the AND combinations.
// [R16] Codes 90, DA: NOR-like and NAND-like combinations.
// [R17] Codes 6D, AD, D6: the OR combinations.
// [R18] Codes 59, 95: exclusive-OR and equivalence.
// [R19] Autostart begins blit when idle and parameters wait.
// [R20] Reserved bit reads zero, writes ignored.
`timescale 1ns/1ps
`include "bsr_regs.svh"
module bsr_blit_ctrl #(
	parameter int ADDR_W = 24,
	parameter int DATA_W = 32,
	parameter int CNT_W = 16
) (
	// Clock and reset.
	input wire logic clk_sys,
	input wire logic rst,
	// Byte-wide register port.
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	// Buffered parameter set from the parameter registers.
	input wire logic param_load,
	input wire logic param_sys_src,
	input wire logic [CNT_W-1:0] param_dwords,
	// Display memory arbitration.
	input wire logic mem_slot,
	// Host display-memory accesses.
	input wire logic host_mem_wr,
	input wire logic host_mem_rd,
	input wire logic [ADDR_W-1:0] host_addr,
	input wire logic [DATA_W-1:0] host_wdata,
	output logic [DATA_W-1:0] host_rdata,
	output logic host_rvalid,
	// Frame-buffer port.
	output logic fb_wr,
	output logic fb_rd,
	output logic [ADDR_W-1:0] fb_addr,
	output logic [DATA_W-1:0] fb_wdata,
	input wire logic [DATA_W-1:0] fb_rdata,
	// Blit source data to the engine datapath.
	output logic src_wr,
	output logic [DATA_W-1:0] src_data,
	// Pixel combine path.
	input wire logic px_valid,
	input wire logic [DATA_W-1:0] px_src,
	input wire logic [DATA_W-1:0] px_dst,
	output logic px_out_valid,
	output logic [DATA_W-1:0] px_out,
	// Engine events.
	output logic blit_launch,
	output logic blit_done,
	output logic eng_reset,
	output logic [7:0] rop_sel
);
	import bsr_pkg::*;

	// Reset image of the start/status register, split into its stored bits.
	localparam logic [7:0] CTRL_INIT = `BSR_CTRL_RESET;

	bsr_state_t state;
	logic auto_en;
	logic sys_loc;
	logic pause;
	logic start_bit;
	logic buf_full;
	logic cur_sys_src;
	logic [CNT_W-1:0] remain;
	logic [DATA_W-1:0] alu_result;
	logic ctrl_wr;
	logic rop_wr;
	logic reset_req;
	logic start_req;
	logic want_launch;
	logic launch;
	logic needs_data;
	logic src_take;
	logic step;
	logic finish;
	logic busy;

	// Register write decode and the requests that a control write makes.
	always_comb begin
		ctrl_wr = 1'b0;
		rop_wr = 1'b0;
		if (reg_wr && reg_addr == `BSR_OFS_CTRL) begin
			ctrl_wr = 1'b1;
		end else if (reg_wr && reg_addr == `BSR_OFS_ROP) begin
			rop_wr = 1'b1;
		end
		reset_req = ctrl_wr & reg_wdata[`BSR_BIT_RESET]; // [R06]
		start_req = ctrl_wr & reg_wdata[`BSR_BIT_START] & ~reset_req; // [R07]
	end

	// Launch, data demand and completion terms of the sequencer.
	always_comb begin
		want_launch = start_bit | (auto_en & buf_full); // [R07] [R19]
		launch = (state == BSR_WAIT_SLOT) & mem_slot & ~reset_req; // [R07]
		needs_data = (state == BSR_RUN) & cur_sys_src & ~pause; // [R01] [R03]
		src_take = needs_data & host_mem_wr; // [R03]
		step = (state == BSR_RUN) & (cur_sys_src ? src_take : (mem_slot & ~pause));
		finish = (state == BSR_RUN) & ~reset_req & ((remain == '0) || (step && remain == 1));
		busy = (state != BSR_IDLE) & ~(pause & (state == BSR_RUN)); // [R09]
	end

	// Blit sequencer: idle, waiting for a memory slot, running.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			state <= BSR_IDLE;
		end else if (reset_req) begin
			state <= BSR_IDLE; // [R06]
		end else begin
			case (state)
				BSR_IDLE: begin
					if (want_launch) begin
						state <= BSR_WAIT_SLOT; // [R07] [R19]
					end
				end
				BSR_WAIT_SLOT: begin
					if (launch) begin
						state <= BSR_RUN;
					end
				end
				BSR_RUN: begin
					if (finish) begin
						state <= BSR_IDLE;
					end
				end
				default: state <= BSR_IDLE;
			endcase
		end
	end

	// Work counter loaded with the waiting parameter set at launch.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			remain <= '0;
			cur_sys_src <= 1'b0;
		end else if (reset_req) begin
			remain <= '0; // [R06]
			cur_sys_src <= 1'b0;
		end else if (launch) begin
			remain <= param_dwords;
			cur_sys_src <= param_sys_src;
		end else if (step && remain != '0) begin
			remain <= remain - 1'b1;
		end
	end

	// Start bit: set by software, cleared by hardware at completion; the set wins.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			start_bit <= 1'b0;
		end else if (reset_req) begin
			start_bit <= 1'b0; // [R06]
		end else if (start_req) begin
			start_bit <= 1'b1; // [R07]
		end else if (finish) begin
			start_bit <= 1'b0; // [R08]
		end
	end

	// Buffered status: a newly loaded set wins over the launch that frees the registers.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			buf_full <= 1'b0;
		end else if (param_load) begin
			buf_full <= 1'b1; // [R05]
		end else if (reset_req || launch) begin
			buf_full <= 1'b0; // [R05] [R06]
		end
	end

	// Plain control bits of the start/status register; reserved bit is not stored.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			auto_en <= CTRL_INIT[`BSR_BIT_AUTO];
			sys_loc <= CTRL_INIT[`BSR_BIT_SYSLOC];
			pause <= CTRL_INIT[`BSR_BIT_PAUSE];
		end else if (ctrl_wr) begin
			auto_en <= reg_wdata[`BSR_BIT_AUTO]; // [R19]
			sys_loc <= reg_wdata[`BSR_BIT_SYSLOC];
			pause <= reg_wdata[`BSR_BIT_PAUSE]; // [R01] [R04] [R20]
		end
	end

	// Raster-operation select register.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			rop_sel <= `BSR_ROP_RESET;
		end else if (rop_wr) begin
			rop_sel <= reg_wdata; // [R10]
		end
	end

	// Register read data, captured on the read strobe; unmapped offsets read zero.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			if (reg_addr == `BSR_OFS_CTRL) begin
				reg_rdata <= {auto_en, sys_loc, pause, buf_full, 1'b0, 1'b0, start_bit, busy}; // [R05] [R09] [R20]
			end else if (reg_addr == `BSR_OFS_ROP) begin
				reg_rdata <= rop_sel;
			end else begin
				reg_rdata <= 8'h00;
			end
		end
	end

	// Engine event pulses.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			blit_launch <= 1'b0;
			blit_done <= 1'b0;
			eng_reset <= 1'b0;
		end else begin
			blit_launch <= launch; // [R07]
			blit_done <= finish; // [R08]
			eng_reset <= reset_req; // [R06]
		end
	end

	// Raster-operation combine of one pixel word.
	bsr_rop_alu #(
		.WIDTH(DATA_W)
	) u_alu (
		.rop(rop_sel),
		.src(px_src),
		.dst(px_dst),
		.result(alu_result)
	);

	// Registered pixel result.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			px_out_valid <= 1'b0;
			px_out <= '0;
		end else begin
			px_out_valid <= px_valid;
			if (px_valid) begin
				px_out <= alu_result; // [R10] [R12]
			end
		end
	end

	// Host access steering.
	bsr_host_route #(
		.ADDR_W(ADDR_W),
		.DATA_W(DATA_W)
	) u_route (
		.clk_sys(clk_sys),
		.rst(rst),
		.needs_data(needs_data),
		.host_mem_wr(host_mem_wr),
		.host_mem_rd(host_mem_rd),
		.host_addr(host_addr),
		.host_wdata(host_wdata),
		.host_rdata(host_rdata),
		.host_rvalid(host_rvalid),
		.fb_wr(fb_wr),
		.fb_rd(fb_rd),
		.fb_addr(fb_addr),
		.fb_wdata(fb_wdata),
		.fb_rdata(fb_rdata),
		.src_wr(src_wr),
		.src_data(src_data)
	);
endmodule

// *** hdl/bsr_host_route.sv ***
// Steers host display-memory accesses to the frame buffer or to the blit source path.
`timescale 1ns/1ps
module bsr_host_route #(
	parameter int ADDR_W = 24,
	parameter int DATA_W = 32
) (
	// Clock and reset.
	input wire logic clk_sys,
	input wire logic rst,
	// Routing decision from the blit control.
	input wire logic needs_data,
	// Host side.
	input wire logic host_mem_wr,
	input wire logic host_mem_rd,
	input wire logic [ADDR_W-1:0] host_addr,
	input wire logic [DATA_W-1:0] host_wdata,
	output logic [DATA_W-1:0] host_rdata,
	output logic host_rvalid,
	// Frame-buffer side.
	output logic fb_wr,
	output logic fb_rd,
	output logic [ADDR_W-1:0] fb_addr,
	output logic [DATA_W-1:0] fb_wdata,
	input wire logic [DATA_W-1:0] fb_rdata,
	// Blit source side.
	output logic src_wr,
	output logic [DATA_W-1:0] src_data
);
	logic rd_pend;

	// Writes go to the engine only while it waits for source data; otherwise straight through.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			fb_wr <= 1'b0;
			src_wr <= 1'b0;
			fb_rd <= 1'b0;
			fb_addr <= '0;
			fb_wdata <= '0;
			src_data <= '0;
		end else begin
			src_wr <= host_mem_wr & needs_data; // [R03]
			fb_wr <= host_mem_wr & ~needs_data; // [R01]
			fb_rd <= host_mem_rd; // [R02]
			if (host_mem_wr | host_mem_rd) begin
				fb_addr <= host_addr; // [R01]
			end
			if (host_mem_wr) begin
				fb_wdata <= host_wdata;
				src_data <= host_wdata;
			end
		end
	end

	// Reads are always serviced; host data returns two cycles after the frame-buffer read strobe.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			rd_pend <= 1'b0;
			host_rvalid <= 1'b0;
			host_rdata <= '0;
		end else begin
			rd_pend <= fb_rd;
			host_rvalid <= rd_pend; // [R02]
			if (rd_pend) begin
				host_rdata <= fb_rdata;
			end
		end
	end
endmodule

// *** hdl/bsr_pkg.sv ***
// Types shared by the blit control modules.
package bsr_pkg;
	typedef enum logic [1:0] {
		BSR_IDLE,
		BSR_WAIT_SLOT,
		BSR_RUN
	} bsr_state_t;
endpackage

// *** hdl/bsr_regs.svh ***
// Register offsets, field positions, reset values and raster-operation codes of the blit control.
`ifndef BSR_REGS_SVH
`define BSR_REGS_SVH

`define BSR_OFS_ROP 8'h1A
`define BSR_OFS_CTRL 8'h40

`define BSR_BIT_BUSY 0
`define BSR_BIT_START 1
`define BSR_BIT_RESET 2
`define BSR_BIT_RSVD 3
`define BSR_BIT_BUFFERED 4
`define BSR_BIT_PAUSE 5
`define BSR_BIT_SYSLOC 6
`define BSR_BIT_AUTO 7

`define BSR_ROP_RESET 8'h0D
`define BSR_CTRL_RESET 8'h00

`define BSR_ROP_ZERO 8'h00
`define BSR_ROP_NS_AND_ND 8'h90
`define BSR_ROP_NS_AND_D 8'h50
`define BSR_ROP_NS 8'hD0
`define BSR_ROP_S_AND_ND 8'h09
`define BSR_ROP_ND 8'h0B
`define BSR_ROP_S_XOR_D 8'h59
`define BSR_ROP_NS_OR_ND 8'hDA
`define BSR_ROP_S_AND_D 8'h05
`define BSR_ROP_S_XNOR_D 8'h95
`define BSR_ROP_D 8'h06
`define BSR_ROP_NS_OR_D 8'hD6
`define BSR_ROP_S 8'h0D
`define BSR_ROP_S_OR_ND 8'hAD
`define BSR_ROP_S_OR_D 8'h6D
`define BSR_ROP_ONE 8'h0E

`endif

// *** hdl/bsr_rop_alu.sv ***
// Two-operand raster-operation function of source or pattern and destination.
`timescale 1ns/1ps
`include "bsr_regs.svh"
module bsr_rop_alu #(
	parameter int WIDTH = 32
) (
	// Operation select.
	input wire logic [7:0] rop,
	// Operands and result.
	input wire logic [WIDTH-1:0] src,
	input wire logic [WIDTH-1:0] dst,
	output logic [WIDTH-1:0] result
);
	// One code per logical function; the first operand may be source or pattern alike.
	always_comb begin
		case (rop) // [R10] [R12]
			`BSR_ROP_ZERO: result = '0; // [R13]
			`BSR_ROP_ONE: result = '1; // [R13]
			`BSR_ROP_ND: result = ~dst; // [R13]
			`BSR_ROP_S: result = src; // [R14]
			`BSR_ROP_D: result = dst; // [R14]
			`BSR_ROP_NS: result = ~src; // [R14]
			`BSR_ROP_S_AND_D: result = src & dst; // [R15]
			`BSR_ROP_S_AND_ND: result = src & ~dst; // [R15]
			`BSR_ROP_NS_AND_D: result = ~src & dst; // [R15]
			`BSR_ROP_NS_AND_ND: result = ~src & ~dst; // [R16]
			`BSR_ROP_NS_OR_ND: result = ~src | ~dst; // [R16]
			`BSR_ROP_S_OR_D: result = src | dst; // [R17]
			`BSR_ROP_S_OR_ND: result = src | ~dst; // [R17]
			`BSR_ROP_NS_OR_D: result = ~src | dst; // [R17]
			`BSR_ROP_S_XOR_D: result = src ^ dst; // [R18]
			`BSR_ROP_S_XNOR_D: result = ~(src ^ dst); // [R18]
			default: result = dst;
		endcase
	end
endmodule

// *** verification/bsr_blit_ctrl_assertions.sv ***
// Concurrent checks on the ports of the blit control.
`timescale 1ns/1ps
`include "bsr_regs.svh"
module bsr_blit_ctrl_assertions #(
	parameter int ADDR_W = 24,
	parameter int DATA_W = 32
) (
	// Clock and reset.
	input wire logic clk_sys,
	input wire logic rst,
	// Register port.
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	input wire logic [7:0] rop_sel,
	// Host and frame-buffer paths.
	input wire logic mem_slot,
	input wire logic host_mem_wr,
	input wire logic host_mem_rd,
	input wire logic [ADDR_W-1:0] host_addr,
	input wire logic [DATA_W-1:0] host_rdata,
	input wire logic host_rvalid,
	input wire logic fb_wr,
	input wire logic fb_rd,
	input wire logic [ADDR_W-1:0] fb_addr,
	input wire logic [DATA_W-1:0] fb_rdata,
	input wire logic src_wr,
	// Pixel path and engine events.
	input wire logic px_valid,
	input wire logic px_out_valid,
	input wire logic blit_launch,
	input wire logic blit_done,
	input wire logic eng_reset
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	// A write to the start/status register.
	wire ctl_wr = reg_wr && reg_addr == `BSR_OFS_CTRL;

	a_launch_slot: assert property (blit_launch |-> $past(mem_slot))
		else $error("launch without a memory slot");
	a_write_route: assert property (host_mem_wr |=> fb_wr != src_wr)
		else $error("host write not routed to exactly one path");
	a_fb_address: assert property (host_mem_wr |=> !fb_wr || fb_addr == $past(host_addr))
		else $error("frame-buffer write lost the host address");
	a_read_path: assert property (host_mem_rd |=> fb_rd ##[1:2] host_rvalid)
		else $error("host read not serviced");
	a_read_data: assert property (host_rvalid |-> host_rdata == $past(fb_rdata))
		else $error("host read data differs from frame buffer");
	a_reset_pulse: assert property (ctl_wr && reg_wdata[2] |-> ##[1:2] eng_reset)
		else $error("engine reset pulse missing");
	a_reset_quiet: assert property (ctl_wr && reg_wdata[2] |-> ##2 !blit_done [*3])
		else $error("aborted blit completed");
	a_rop_write: assert property (reg_wr && reg_addr == `BSR_OFS_ROP |=> rop_sel == $past(reg_wdata))
		else $error("raster operation not stored");
	a_rsvd_zero: assert property (reg_rd && reg_addr == `BSR_OFS_CTRL |=> reg_rdata[3:2] == 2'h0)
		else $error("reserved or reset bit read as one");
	a_px_pulse: assert property (px_valid |=> px_out_valid)
		else $error("pixel result missing");

	c_launch: cover property (blit_launch);
	c_done: cover property (blit_done);
	c_reset: cover property (eng_reset);
endmodule

// *** verification/bsr_blit_ctrl_tb_top.sv ***
// Self-checking bench for the blit start/status and raster-operation control.
`timescale 1ns/1ps
`include "bsr_regs.svh"
module bsr_blit_ctrl_tb_top;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic reg_wr = 1'b0, reg_rd = 1'b0, param_load = 1'b0, param_sys_src = 1'b0, mem_slot = 1'b0;
	logic host_mem_wr = 1'b0, host_mem_rd = 1'b0, px_valid = 1'b0;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, rop_sel;
	logic [15:0] param_dwords = 16'h0000;
	logic [23:0] host_addr = 24'h000100, fb_addr;
	logic [31:0] host_wdata = 32'h1234_5678, px_src = 32'hF0F0_3C3C, px_dst = 32'hCCAA_5A0F;
	logic [31:0] fb_rdata, host_rdata, fb_wdata, src_data, px_out;
	logic host_rvalid, fb_wr, fb_rd, src_wr, px_out_valid, blit_launch, blit_done, eng_reset;
	logic [7:0] codes [16] = '{8'h00, 8'h90, 8'h50, 8'hD0, 8'h09, 8'h0B, 8'h59, 8'hDA,
		8'h05, 8'h95, 8'h06, 8'hD6, 8'h0D, 8'hAD, 8'h6D, 8'h0E};
	int err_count = 0;
	int checked = 0;

	bsr_blit_ctrl dut_u (
		.clk_sys(clk_sys),
		.rst(rst),
		.reg_addr(reg_addr),
		.reg_wr(reg_wr),
		.reg_rd(reg_rd),
		.reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata),
		.param_load(param_load),
		.param_sys_src(param_sys_src),
		.param_dwords(param_dwords),
		.mem_slot(mem_slot),
		.host_mem_wr(host_mem_wr),
		.host_mem_rd(host_mem_rd),
		.host_addr(host_addr),
		.host_wdata(host_wdata),
		.host_rdata(host_rdata),
		.host_rvalid(host_rvalid),
		.fb_wr(fb_wr),
		.fb_rd(fb_rd),
		.fb_addr(fb_addr),
		.fb_wdata(fb_wdata),
		.fb_rdata(fb_rdata),
		.src_wr(src_wr),
		.src_data(src_data),
		.px_valid(px_valid),
		.px_src(px_src),
		.px_dst(px_dst),
		.px_out_valid(px_out_valid),
		.px_out(px_out),
		.blit_launch(blit_launch),
		.blit_done(blit_done),
		.eng_reset(eng_reset),
		.rop_sel(rop_sel)
	);
	bsr_fb_model fb_u (
		.clk_sys(clk_sys),
		.fb_rd(fb_rd),
		.fb_addr(fb_addr),
		.fb_rdata(fb_rdata)
	);

	// Free-running system clock.
	initial forever #10 clk_sys = ~clk_sys;

	// Expected pixel for each raster-operation code.
	function automatic logic [31:0] rop_f(input logic [7:0] c, input logic [31:0] s, d);
		case (c)
			8'h00: return 32'h0;
			8'h90: return ~(s | d);
			8'h50: return ~s & d;
			8'hD0: return ~s;
			8'h09: return s & ~d;
			8'h0B: return ~d;
			8'h59: return s ^ d;
			8'hDA: return ~(s & d);
			8'h05: return s & d;
			8'h95: return ~(s ^ d);
			8'hD6: return ~s | d;
			8'h0D: return s;
			8'hAD: return s | ~d;
			8'h6D: return s | d;
			8'h0E: return 32'hFFFF_FFFF;
			default: return d;
		endcase
	endfunction

	task automatic print_verdict();
		$display("Comparisons %0d, mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask

	// Each task starts and ends just after a rising edge.
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(posedge clk_sys) #1;
		reg_wr = 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		reg_addr = a;
		reg_rd = 1'b1;
		@(posedge clk_sys) #1;
		reg_rd = 1'b0;
		@(posedge clk_sys) #1;
		chk("reg_rdata", {24'h0, exp}, {24'h0, reg_rdata});
	endtask

	task automatic tick(ref logic s);
		s = 1'b1;
		@(posedge clk_sys) #1;
		s = 1'b0;
	endtask

	task automatic hwr(input logic to_fb);
		host_addr = host_addr + 24'h000004;
		host_wdata = ~host_wdata;
		tick(host_mem_wr);
		chk("fb_wr", {31'h0, to_fb}, {31'h0, fb_wr});
		chk("src_wr", {31'h0, !to_fb}, {31'h0, src_wr});
		if (to_fb) begin
			chk("fb_addr", {8'h0, host_addr}, {8'h0, fb_addr});
			chk("fb_wdata", host_wdata, fb_wdata);
		end else begin
			chk("src_data", host_wdata, src_data);
		end
	endtask

	task automatic load(input logic sys, input logic [15:0] n);
		param_sys_src = sys;
		param_dwords = n;
		tick(param_load);
	endtask

	// Offers memory slots until the blit completes or n cycles pass; a finished blit needs none.
	task automatic run_slots(input int n);
		int i;
		if (blit_done !== 1'b1) begin
			mem_slot = 1'b1;
			for (i = 0; i < n && blit_done !== 1'b1; i++) @(posedge clk_sys) #1;
			mem_slot = 1'b0;
		end
	endtask

	// Watchdog against a hung sequence.
	initial begin
		#100000;
		err_count++;
		print_verdict();
	end

	initial begin
		repeat (5) @(posedge clk_sys);
		#1 rst = 1'b0;
		@(posedge clk_sys) #1;
		rd(`BSR_OFS_CTRL, `BSR_CTRL_RESET);
		rd(`BSR_OFS_ROP, `BSR_ROP_RESET);
		rd(8'h55, 8'h00);
		wr(`BSR_OFS_CTRL, 8'h08);
		rd(`BSR_OFS_CTRL, 8'h00);
		// Colour expansion is never enabled here, so source-free codes are legal.
		for (int k = 0; k < 16; k++) begin
			wr(`BSR_OFS_ROP, codes[k]);
			tick(px_valid);
			chk("px_out", rop_f(codes[k], px_src, px_dst), px_out);
		end
		// Blit sourced from display memory.
		load(1'b0, 16'h0003);
		rd(`BSR_OFS_CTRL, 8'h10);
		wr(`BSR_OFS_CTRL, 8'h02);
		@(posedge clk_sys) #1;
		rd(`BSR_OFS_CTRL, 8'h13);
		run_slots(20);
		chk("blit_done", 1, blit_done);
		rd(`BSR_OFS_CTRL, 8'h00);
		// Blit sourced from the host, paused in the middle.
		load(1'b1, 16'h0002);
		wr(`BSR_OFS_CTRL, 8'h02);
		@(posedge clk_sys) #1;
		tick(mem_slot);
		chk("blit_launch", 1, blit_launch);
		hwr(1'b0);
		wr(`BSR_OFS_CTRL, 8'h20);
		hwr(1'b1);
		rd(`BSR_OFS_CTRL, 8'h22);
		tick(host_mem_rd);
		for (int i = 0; i < 4 && host_rvalid !== 1'b1; i++) @(posedge clk_sys) #1;
		chk("host_rvalid", 1, host_rvalid);
		chk("host_rdata", {8'hA5, host_addr}, host_rdata);
		wr(`BSR_OFS_CTRL, 8'h00);
		hwr(1'b0);
		run_slots(5);
		chk("blit_done", 1, blit_done);
		hwr(1'b1);
		rd(`BSR_OFS_CTRL, 8'h00);
		// Abort by engine reset.
		load(1'b0, 16'h0005);
		wr(`BSR_OFS_CTRL, 8'h02);
		@(posedge clk_sys) #1;
		tick(mem_slot);
		chk("blit_launch", 1, blit_launch);
		wr(`BSR_OFS_CTRL, 8'h04);
		if (eng_reset !== 1'b1)
			@(posedge clk_sys) #1;
		chk("eng_reset", 1, eng_reset);
		rd(`BSR_OFS_CTRL, 8'h00);
		run_slots(10);
		chk("blit_done", 0, blit_done);
		// Autostart from a waiting parameter set.
		wr(`BSR_OFS_CTRL, 8'h80);
		load(1'b0, 16'h0001);
		run_slots(10);
		chk("blit_done", 1, blit_done);
		rd(`BSR_OFS_CTRL, 8'h80);
		// System reset before launch: a started blit and the raster operation return to reset.
		wr(`BSR_OFS_ROP, 8'h59);
		wr(`BSR_OFS_CTRL, 8'h02);
		rst = 1'b1;
		repeat (2) @(posedge clk_sys);
		#1 rst = 1'b0;
		rd(`BSR_OFS_CTRL, `BSR_CTRL_RESET);
		rd(`BSR_OFS_ROP, `BSR_ROP_RESET);
		run_slots(5);
		chk("blit_done", 0, blit_done);
		print_verdict();
	end
endmodule

bind bsr_blit_ctrl bsr_blit_ctrl_assertions #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) chk_u (
	.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .rop_sel(rop_sel), .mem_slot(mem_slot),
	.host_mem_wr(host_mem_wr), .host_mem_rd(host_mem_rd), .host_addr(host_addr),
	.host_rdata(host_rdata), .host_rvalid(host_rvalid), .fb_wr(fb_wr), .fb_rd(fb_rd),
	.fb_addr(fb_addr), .fb_rdata(fb_rdata), .src_wr(src_wr), .px_valid(px_valid),
	.px_out_valid(px_out_valid), .blit_launch(blit_launch), .blit_done(blit_done),
	.eng_reset(eng_reset));

// *** verification/bsr_fb_model.sv ***
// Frame-buffer model answering the block's read requests.
`timescale 1ns/1ps
module bsr_fb_model (
	// Clock.
	input wire logic clk_sys,
	// Requests from the block.
	input wire logic fb_rd,
	input wire logic [23:0] fb_addr,
	// Read data back to the block.
	output logic [31:0] fb_rdata
);
	// Data is valid only the cycle after a read; otherwise the lines show its inverse.
	always @(posedge clk_sys) begin
		fb_rdata <= fb_rd ? {8'hA5, fb_addr} : {8'h5A, ~fb_addr};
	end
endmodule
